// *** wost_pkg.sv ***
package wost_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ONESHOT = 12'h004;
  localparam logic [11:0] OFS_PRESCALE = 12'h008;
  localparam logic [11:0] OFS_PRIMARY = 12'h00C;
  localparam logic [11:0] OFS_SECONDARY = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
  localparam logic [9:0] IDX_PIN_CTRL = 10'h10A;
  localparam logic [11:0] OFS_PIN_CTRL = {IDX_PIN_CTRL, 2'b00};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_STATUS = 1;
  localparam int CTRL_FORCE = 2;
  localparam int CTRL_SRC_LO = 4;
  localparam int OS_START = 0;
  localparam int OS_STOP = 1;
  localparam int OS_ACTIVE = 2;
  localparam int PIN_LEVEL = 0;
  localparam int PIN_SWITCH = 1;
  localparam int PIN_TRIG_EN = 2;
  localparam int PIN_POL = 3;
  localparam int IRQ_PULSE_END = 0;

  // ---------------------------------------------------------------
  // Count source selects and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [7:0] RST_COUNT = 8'hFF;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam int STOP_WAIT_MAX = 24;

  typedef enum logic {PH_WAIT, PH_PULSE} wost_phase_e;

endpackage

// *** wost_timer.sv ***
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
// Function
// - Reset leaves timer stopped; counting waits for software count start.
// - Prescaler and counter are read as separate words, no coherence.
// - Clearing start or one-shot stop reloads counters and halts.
// - Status flag rises one to two count-source ticks after start.
// - Counting begins at first count-source tick after active flag rises.
// - Status flag falls one to two ticks after start clears.
// - Forced stop halts the timer immediately, no latency.
// - One-shot start or stop changes active flag after one or two ticks.
// - Start and stop crossing leaves active flag either value.
// - Trigger while one-shot active is ignored.
// - Wait counts primary; primary underflow loads secondary for pulse.
// - Secondary underflow reloads primary and clears active flag.
// - Interrupt event coincides with end of output pulse.
module wost_timer
  import wost_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic countSrcTick,
  input wire logic externalTriggerPin,
  output logic pulseOutputPin,
  output logic timerIrq
);

  typedef struct packed {
    logic startCtl;
    logic startSeen;
    logic cntStat;
    logic [1:0] srcSel;
    logic [2:0] divCnt;
    logic active;
    logic trigPend;
    logic trigSeen;
    logic stopPend;
    logic stopSeen;
    wost_phase_e phase;
    logic [7:0] preRld;
    logic [7:0] priRld;
    logic [7:0] secRld;
    logic [7:0] preCnt;
    logic [7:0] cnt;
    logic outLvl;
    logic outSw;
    logic pinTrigEn;
    logic trigPol;
    logic pinSync0;
    logic pinSync1;
    logic pinPrev;
    logic irqStat;
    logic irqMask;
    logic irq;
    logic pulseOut;
    logic wrPend;
    logic [11:0] wrAddr;
    logic rdPend;
    logic [11:0] rdAddr;
    logic readyOut;
    logic [31:0] rdata;
  } wost_state_s;

  wost_state_s st_r;
  wost_state_s st_nxt;
  logic tick;
  logic pinEdge;
  logic trigReq;
  logic stopReq;
  logic forceStop;
  logic waitUf;
  logic pulseUf;
  logic wrCtl;
  logic wrOs;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    wrCtl = st_r.wrPend && st_r.wrAddr == OFS_CTRL;
    wrOs = st_r.wrPend && st_r.wrAddr == OFS_ONESHOT;
    waitUf = 1'b0;
    pulseUf = 1'b0;

    // Count source as a one-cycle enable
    st_nxt.divCnt = st_r.divCnt + 3'h1;
    if (st_r.srcSel == SRC_DIV1) begin
      tick = 1'b1;
    end else if (st_r.srcSel == SRC_DIV2) begin
      tick = st_r.divCnt[0];
    end else if (st_r.srcSel == SRC_DIV8) begin
      tick = st_r.divCnt == DIV8_LAST;
    end else begin
      tick = countSrcTick;
    end

    // Pin synchroniser; edge taken from the second stage only
    st_nxt.pinSync0 = externalTriggerPin;
    st_nxt.pinSync1 = st_r.pinSync0;
    st_nxt.pinPrev = st_r.pinSync1;
    pinEdge = st_r.trigPol ? (st_r.pinSync1 && !st_r.pinPrev) : (!st_r.pinSync1 && st_r.pinPrev);

    forceStop = wrCtl && hwdata[CTRL_FORCE];
    stopReq = wrOs && hwdata[OS_STOP];
    // Triggers only while counting and idle; active retrigger dropped
    trigReq = ((wrOs && hwdata[OS_START]) || (st_r.pinTrigEn && pinEdge))
              && st_r.cntStat && !st_r.active && !stopReq;

    if (tick) begin
      st_nxt.startSeen = st_r.startCtl;
      st_nxt.cntStat = st_r.startSeen;
      if (st_r.trigSeen) begin
        st_nxt.active = 1'b1;
        st_nxt.phase = PH_WAIT;
      end
      st_nxt.trigSeen = st_r.trigPend && !stopReq;
      st_nxt.trigPend = 1'b0;
      st_nxt.stopSeen = st_r.stopPend;
      st_nxt.stopPend = 1'b0;

      // Down counting; prescaler underflow clocks the main counter
      if (st_r.cntStat && st_r.active) begin
        if (st_r.preCnt == RST_ZERO8) begin
          st_nxt.preCnt = st_r.preRld;
          if (st_r.cnt != RST_ZERO8) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
          end else if (st_r.phase == PH_WAIT) begin
            waitUf = 1'b1;
            st_nxt.cnt = st_r.secRld;
            st_nxt.phase = PH_PULSE;
          end else begin
            pulseUf = 1'b1;
            st_nxt.cnt = st_r.priRld;
            st_nxt.phase = PH_WAIT;
            st_nxt.active = 1'b0;
          end
        end else begin
          st_nxt.preCnt = st_r.preCnt - 8'h01;
        end
      end

      // Stop paths reload from the reload registers
      if (st_r.stopSeen || (st_r.cntStat && !st_r.startSeen)) begin
        st_nxt.active = 1'b0;
        st_nxt.phase = PH_WAIT;
        st_nxt.cnt = st_r.priRld;
        st_nxt.preCnt = st_r.preRld;
      end
    end

    // One-shot start/stop, two-stage so the flag moves after 1..2 ticks
    // Placed after the tick stage: a request in a tick cycle must not be lost
    if (trigReq && !st_r.trigSeen) begin
      st_nxt.trigPend = 1'b1;
    end
    if (stopReq) begin
      // A stop overtakes a pending start; flag ends at either value
      st_nxt.stopPend = 1'b1;
      st_nxt.trigPend = 1'b0;
    end

    // Register writes, data phase
    if (wrCtl) begin
      st_nxt.startCtl = hwdata[CTRL_START];
      st_nxt.srcSel = hwdata[CTRL_SRC_LO +: 2];
    end
    if (st_r.wrPend && st_r.wrAddr == OFS_PRESCALE) begin
      st_nxt.preRld = hwdata[7:0];
      if (!st_r.cntStat) begin
        st_nxt.preCnt = hwdata[7:0];
      end
    end
    if (st_r.wrPend && st_r.wrAddr == OFS_PRIMARY) begin
      st_nxt.priRld = hwdata[7:0];
      if (!st_r.cntStat) begin
        st_nxt.cnt = hwdata[7:0];
      end
    end
    if (st_r.wrPend && st_r.wrAddr == OFS_SECONDARY) begin
      st_nxt.secRld = hwdata[7:0];
    end
    if (st_r.wrPend && st_r.wrAddr == OFS_PIN_CTRL) begin
      st_nxt.outLvl = hwdata[PIN_LEVEL];
      st_nxt.outSw = hwdata[PIN_SWITCH];
      st_nxt.pinTrigEn = hwdata[PIN_TRIG_EN];
      st_nxt.trigPol = hwdata[PIN_POL];
    end
    if (st_r.wrPend && st_r.wrAddr == OFS_IRQ_MASK) begin
      st_nxt.irqMask = hwdata[IRQ_PULSE_END];
    end
    // Write-one-clear; a same-cycle pulse end still sets
    if (st_r.wrPend && st_r.wrAddr == OFS_IRQ_STAT && hwdata[IRQ_PULSE_END]) begin
      st_nxt.irqStat = 1'b0;
    end
    if (pulseUf) begin
      st_nxt.irqStat = 1'b1;
    end

    // Forced stop skips the status latency entirely
    if (forceStop) begin
      st_nxt.startCtl = 1'b0;
      st_nxt.startSeen = 1'b0;
      st_nxt.cntStat = 1'b0;
      st_nxt.active = 1'b0;
      st_nxt.trigPend = 1'b0;
      st_nxt.trigSeen = 1'b0;
      st_nxt.stopPend = 1'b0;
      st_nxt.stopSeen = 1'b0;
      st_nxt.phase = PH_WAIT;
      st_nxt.cnt = st_nxt.priRld;
      st_nxt.preCnt = st_nxt.preRld;
    end

    // Bus slave: writes and unmapped reads zero wait, register reads one wait state
    st_nxt.wrPend = 1'b0;
    st_nxt.readyOut = 1'b1;
    if (st_r.rdPend) begin
      st_nxt.rdPend = 1'b0;
      // Prescaler and counter read live, each on its own access
      if (st_r.rdAddr == OFS_CTRL) begin
        st_nxt.rdata = {26'h0, st_r.srcSel, 1'b0, 1'b0, st_r.cntStat, st_r.startCtl};
      end else if (st_r.rdAddr == OFS_ONESHOT) begin
        st_nxt.rdata = {29'h0, st_r.active, 2'b00};
      end else if (st_r.rdAddr == OFS_PRESCALE) begin
        st_nxt.rdata = {24'h0, st_r.preCnt};
      end else if (st_r.rdAddr == OFS_PRIMARY) begin
        st_nxt.rdata = {24'h0, st_r.cnt};
      end else if (st_r.rdAddr == OFS_SECONDARY) begin
        st_nxt.rdata = {24'h0, st_r.secRld};
      end else if (st_r.rdAddr == OFS_IRQ_STAT) begin
        st_nxt.rdata = {31'h0, st_r.irqStat};
      end else if (st_r.rdAddr == OFS_IRQ_MASK) begin
        st_nxt.rdata = {31'h0, st_r.irqMask};
      end else if (st_r.rdAddr == OFS_PIN_CTRL) begin
        st_nxt.rdata = {28'h0, st_r.trigPol, st_r.pinTrigEn, st_r.outSw, st_r.outLvl};
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end else if (hsel && htrans[1] && hready && haddr[31:12] == 20'h0) begin
      st_nxt.wrPend = hwrite;
      st_nxt.wrAddr = haddr[11:0];
      st_nxt.rdPend = !hwrite;
      st_nxt.rdAddr = haddr[11:0];
      st_nxt.readyOut = hwrite;
    end else if (hsel && htrans[1] && hready) begin
      st_nxt.rdata = 32'h0;
    end

    st_nxt.pulseOut = st_nxt.outLvl ^ (st_nxt.active && st_nxt.phase == PH_PULSE);
    st_nxt.irq = st_nxt.irqStat && st_nxt.irqMask;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.preRld <= RST_COUNT;
      st_r.priRld <= RST_COUNT;
      st_r.secRld <= RST_COUNT;
      st_r.preCnt <= RST_COUNT;
      st_r.cnt <= RST_COUNT;
      st_r.readyOut <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.readyOut;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign pulseOutputPin = st_r.pulseOut;
  assign timerIrq = st_r.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  localparam int StopWaitMax = STOP_WAIT_MAX;

  no_start_idle_a: assert property (!st_r.startCtl && !st_r.startSeen && !forceStop |=> !$rose(st_r.cntStat))
    else $error("status rose without start");
  start_latency_a: assert property (wrCtl && hwdata[CTRL_START] && !forceStop && !st_r.startSeen
                                    && !st_r.cntStat |=> !st_r.cntStat)
    else $error("status rose too early");
  stop_latency_a: assert property (wrCtl && !hwdata[CTRL_START] && !forceStop && st_r.cntStat
                                   && st_r.startSeen |=> st_r.cntStat)
    else $error("status fell too early");
  force_stop_a: assert property (forceStop |=> !st_r.cntStat && !st_r.active && !st_r.startCtl)
    else $error("forced stop not immediate");
  os_stop_a: assert property (stopReq && st_r.active && !forceStop |-> ##[1:StopWaitMax]
                              (!st_r.active && st_r.phase == PH_WAIT))
    else $error("one-shot stop did not halt");
  os_start_lag_a: assert property (trigReq |=> !st_r.active)
    else $error("active flag changed at once");
  no_retrigger_a: assert property (st_r.active && !tick |=> !st_r.trigPend)
    else $error("retrigger while active");
  wait_to_pulse_a: assert property (waitUf && !forceStop |=> st_r.phase == PH_PULSE
                                    && st_r.cnt == $past(st_r.secRld))
    else $error("secondary not loaded");
  pulse_end_a: assert property (pulseUf && !forceStop |=> !st_r.active && st_r.irqStat
                                ##1 (pulseOutputPin == st_r.outLvl || st_r.active))
    else $error("pulse end wrong");
  out_level_a: assert property (pulseOutputPin == (st_r.outLvl ^ (st_r.active
                                && st_r.phase == PH_PULSE)))
    else $error("output level wrong");
  pin_trig_a: assert property (st_r.pinTrigEn && pinEdge && st_r.cntStat && !st_r.active
                               && !st_r.trigSeen && !st_r.wrPend |=> st_r.trigPend || st_r.trigSeen)
    else $error("pin trigger lost");

  pulse_end_c: cover property (pulseUf);
  pin_trig_c: cover property (st_r.pinTrigEn && pinEdge && trigReq);
  force_stop_c: cover property (forceStop && st_r.active);
  irq_c: cover property ($rose(timerIrq));

endmodule

// *** wost_pin_model.sv ***
`timescale 1ns/10ps
module wost_pin_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fireEdge,
  input wire logic idleLvl,
  input wire logic pulseOutputPin,
  output logic externalTriggerPin,
  output logic pulseDone,
  output logic [15:0] pulseLen
);
  logic [15:0] cnt_r;
  logic prevPin_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      externalTriggerPin <= 1'b0;
      pulseDone <= 1'b0;
      pulseLen <= 16'h0;
      cnt_r <= 16'h0;
      prevPin_r <= 1'b0;
    end else begin
      // One edge per request, pin is always driven
      if (fireEdge) externalTriggerPin <= ~externalTriggerPin;
      prevPin_r <= pulseOutputPin;
      pulseDone <= 1'b0;
      if (pulseOutputPin != idleLvl) cnt_r <= cnt_r + 16'h1;
      else begin
        // Level select change moves the pin, only a real edge ends a pulse
        if (pulseOutputPin != prevPin_r && cnt_r != 16'h0) begin
          pulseDone <= 1'b1;
          pulseLen <= cnt_r;
        end
        cnt_r <= 16'h0;
      end
    end
  end
endmodule

// *** test_wait_one_shot_timer_control.sv ***
`timescale 1ns/10ps
module test_wait_one_shot_timer_control
  import wost_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, countSrcTick = 1'b0;
  logic fireEdge = 1'b0, idleLvl = 1'b0, rdPh = 1'b0, lvl;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pre, pri, sec;
  logic [1:0] htrans = 2'h0, src;
  logic [2:0] hsize = 3'h2;
  logic hrdy, hresp, extPin, pulseOutputPin, timerIrq, pulseDone;
  logic [15:0] pulseLen;
  int errorCnt = 0, nChecks = 0, pulseSeen = 0, f;
  logic [31:0] expQ[$], plQ[$];
  string nmQ[$];
  localparam logic [11:0] RADDR [8] = '{OFS_CTRL, OFS_ONESHOT, OFS_PRESCALE, OFS_PRIMARY, OFS_SECONDARY,
    OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_PIN_CTRL};
  localparam logic [7:0] RVAL [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  wost_timer u_wost_timer (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .countSrcTick(countSrcTick), .externalTriggerPin(extPin),
    .pulseOutputPin(pulseOutputPin), .timerIrq(timerIrq));
  wost_pin_model u_wost_pin_model (.core_clk(core_clk), .rst(rst), .fireEdge(fireEdge), .idleLvl(idleLvl),
    .pulseOutputPin(pulseOutputPin), .externalTriggerPin(extPin), .pulseDone(pulseDone), .pulseLen(pulseLen));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // External source ticks every second clock, so its counts come out doubled
  always @(posedge core_clk) countSrcTick <= ~countSrcTick;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic far, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {19'h0, far, a};
    hwrite <= w;
    do @(posedge core_clk); while (!hrdy);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (!hrdy);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    expQ.push_back(e);
    nmQ.push_back(nm);
    bus(1'b0, 1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic waitPulse(input int n, input int lim);
    for (int k = 0; k < lim && pulseSeen < n; k++) @(negedge core_clk);
    @(posedge core_clk);
  endtask
  task automatic printVerdict();
    if (errorCnt == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (rdPh && hrdy) chk("response", {31'h0, hresp}, 32'h0);
    if (rdPh && hrdy) chk(nmQ.pop_front(), hrdata, expQ.pop_front());
    if (hrdy) rdPh = hsel && htrans[1] && !hwrite;
    if (pulseDone) begin
      pulseSeen++;
      chk("pulse width", {16'h0, pulseLen}, plQ.pop_front());
    end
  end

  initial begin
    idle(20000);
    errorCnt++;
    printVerdict();
  end

  initial begin
    void'($urandom(50));
    idle(10);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) rd(RADDR[i], {24'h0, RVAL[i]}, "reset value");
    expQ.push_back(32'h0);
    nmQ.push_back("unmapped");
    bus(1'b0, 1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, 1'b1, OFS_PIN_CTRL, 32'hF);
    rd(OFS_PIN_CTRL, 32'h0, "unmapped write");
    wr(OFS_ONESHOT, 32'h1);
    idle(8);
    rd(OFS_ONESHOT, 32'h0, "trigger stopped");
    rd(OFS_CTRL, 32'h0, "stopped");
    for (int i = 0; i < 4; i++) begin
      pre = $urandom_range(3);
      pri = 16 + $urandom_range(7);
      sec = $urandom_range(7);
      src = i[0] ? SRC_EXT : SRC_DIV1;
      f = i[0] ? 2 : 1;
      lvl = i[1] ^ i[0];
      wr(OFS_CTRL, 32'h0);
      idle(8);
      // Written while stopped, so counters load too and no spacing applies
      wr(OFS_PRESCALE, pre);
      wr(OFS_PRIMARY, pri);
      wr(OFS_SECONDARY, sec);
      wr(OFS_IRQ_MASK, {31'h0, i[1]});
      wr(OFS_PIN_CTRL, 32'hFFFFFFF0 | {28'h0, ~extPin, i[1], 1'b0, lvl});
      rd(OFS_PIN_CTRL, {28'h0, ~extPin, i[1], 1'b0, lvl}, "pin control");
      idleLvl <= lvl;
      wr(OFS_CTRL, {26'h0, src, 4'h1});
      idle(6);
      chk("idle level", {31'h0, pulseOutputPin}, {31'h0, lvl});
      rd(OFS_CTRL, {26'h0, src, 4'h3}, "status");
      plQ.push_back((pre + 1) * (sec + 1) * f);
      if (i[1]) begin
        fireEdge <= 1'b1;
        idle(1);
        fireEdge <= 1'b0;
      end else begin
        wr(OFS_ONESHOT, 32'h1);
      end
      idle(8);
      rd(OFS_ONESHOT, 32'h4, "active");
      wr(OFS_ONESHOT, 32'h1);
      waitPulse(i + 1, (pre + 1) * (pri + sec + 2) * f - 1);
      chk("pulses", pulseSeen, i + 1);
      idle(2);
      chk("irq line", {31'h0, timerIrq}, {31'h0, i[1]});
      rd(OFS_ONESHOT, 32'h0, "done");
      rd(OFS_PRIMARY, pri, "primary reload");
      rd(OFS_IRQ_STAT, 32'h1, "irq status");
      wr(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, 32'h0, "irq clear");
      chk("irq line", {31'h0, timerIrq}, 32'h0);
    end
    wr(OFS_CTRL, 32'h0);
    idle(8);
    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_CTRL, 32'h21);
    rd(OFS_CTRL, 32'h21, "start lag");
    idle(20);
    rd(OFS_CTRL, 32'h23, "started");
    wr(OFS_ONESHOT, 32'h1);
    idle(40);
    wr(OFS_ONESHOT, 32'h2);
    rd(OFS_ONESHOT, 32'h4, "stop lag");
    idle(20);
    rd(OFS_ONESHOT, 32'h0, "one-shot stop");
    rd(OFS_PRIMARY, pri, "stop reload");
    wr(OFS_CTRL, 32'h20);
    rd(OFS_CTRL, 32'h22, "halt lag");
    idle(20);
    rd(OFS_CTRL, 32'h20, "halted");
    wr(OFS_CTRL, 32'h21);
    idle(20);
    wr(OFS_CTRL, 32'h25);
    rd(OFS_CTRL, 32'h20, "forced stop");
    chk("pulses", pulseSeen, 4);
    idle(4);
    printVerdict();
  end
endmodule
